/* File: design/fsc_pkg.sv */
// shared constants and carrier types for the synthesizer control block
package fsc_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_CFG3    = 5'h00;
  localparam logic [4:0] OFS_FRAC    = 5'h04;
  localparam logic [4:0] OFS_MODULUS = 5'h08;
  localparam logic [4:0] OFS_PHASE   = 5'h0C;
  localparam logic [4:0] OFS_CTRL    = 5'h10;
  localparam logic [4:0] OFS_STATUS  = 5'h14;
  // third configuration word fields
  localparam int CSR_EN_BIT = 18;
  localparam int MODE_HI    = 16;
  localparam int MODE_LO    = 15;
  localparam int TMR_HI     = 14;
  localparam int TMR_LO     = 3;
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_FAST   = 2'h1;
  localparam logic [1:0] MODE_RESYNC = 2'h2;
  // control register fields
  localparam int CTRL_DITHER_BIT = 0;
  localparam int CTRL_RESEED_BIT = 1;
  // reset values, modulus floor and slip cell limit
  localparam logic [31:0] RST_CFG3    = 32'h0000_0000;
  localparam logic [11:0] RST_FRAC    = 12'h000;
  localparam logic [11:0] RST_MODULUS = 12'h002;
  localparam logic [11:0] RST_PHASE   = 12'h001;
  localparam logic [11:0] MOD_MIN     = 12'h002;
  localparam logic [2:0]  MAX_CELLS   = 3'h7;
  // link input bit positions after synchronisation
  localparam int LNK_PFD  = 3;
  localparam int LNK_UP   = 2;
  localparam int LNK_DN   = 1;
  localparam int LNK_OVER = 0;
  // dither generator
  localparam logic [20:0] LFSR_SEED = 21'h000001;
  typedef struct packed {
    logic pfd_ref;
    logic slip_up;
    logic slip_dn;
    logic overshoot;
  } link_in_t;
  typedef struct packed {
    logic [11:0] frac;
    logic [11:0] modulus;
    logic [11:0] phase;
    logic        dither_en;
  } sdm_cfg_t;
endpackage

/* File: design/sigma_delta_interpolator.sv */
// third-order sigma-delta fractional interpolator with dither and seed
module sigma_delta_interpolator (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  fsc_pkg::sdm_cfg_t      cfg,
  input  wire logic              reseed,
  input  wire logic              step,
  output logic signed [3:0]      code_q
);
  logic [11:0] acc1_q, acc1_d, acc2_q, acc2_d, acc3_q, acc3_d;
  logic        c2p_q, c2p_d, c3p_q, c3p_d, c3pp_q, c3pp_d;
  logic [20:0] lfsr_q, lfsr_d;
  logic signed [3:0] code_d;
  logic [12:0] s1, s2, s3;
  logic [12:0] inc;

  // modular add: returns carry and residue, inputs below twice the modulus
  function automatic logic [12:0] mod_add(input logic [11:0] a,
                                          input logic [12:0] b,
                                          input logic [11:0] m);
    logic [13:0] sum;
    sum = {2'b00, a} + {1'b0, b};
    if (sum >= {2'b00, m}) begin
      mod_add = {1'b1, 12'(sum - {2'b00, m})};
    end else begin
      mod_add = {1'b0, sum[11:0]};
    end
  endfunction

  always_comb begin
    acc1_d = acc1_q; acc2_d = acc2_q; acc3_d = acc3_q;
    c2p_d = c2p_q; c3p_d = c3p_q; c3pp_d = c3pp_q;
    lfsr_d = lfsr_q; code_d = code_q;
    // dither adds a pseudo-random lsb so the sequence stretches to 2^21 - 1
    inc = {1'b0, cfg.frac} + {12'h000, cfg.dither_en & lfsr_q[0]};
    s1 = mod_add(acc1_q, inc, cfg.modulus);
    s2 = mod_add(acc2_q, {1'b0, s1[11:0]}, cfg.modulus);
    s3 = mod_add(acc3_q, {1'b0, s2[11:0]}, cfg.modulus);
    if (reseed) begin
      acc1_d = cfg.phase;
      acc2_d = 12'h000; acc3_d = 12'h000;
      c2p_d = 1'b0; c3p_d = 1'b0; c3pp_d = 1'b0;
      lfsr_d = fsc_pkg::LFSR_SEED;
      code_d = 4'sh0;
    end else if (step) begin
      // one advance per reference cycle, cascade of three stages
      acc1_d = s1[11:0]; acc2_d = s2[11:0]; acc3_d = s3[11:0];
      c2p_d = s2[12]; c3p_d = s3[12]; c3pp_d = c3p_q;
      lfsr_d = {lfsr_q[19:0], lfsr_q[20] ^ lfsr_q[18]};
      // repeat length with dither off follows from modulus arithmetic
      code_d = 4'(signed'({3'b000, s1[12]}) + signed'({3'b000, s2[12]})
             - signed'({3'b000, c2p_q}) + signed'({3'b000, s3[12]})
             - signed'({2'b00, c3p_q, 1'b0}) + signed'({3'b000, c3pp_q}));
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acc1_q <= 12'h000; acc2_q <= 12'h000; acc3_q <= 12'h000;
      c2p_q <= 1'b0; c3p_q <= 1'b0; c3pp_q <= 1'b0;
      lfsr_q <= fsc_pkg::LFSR_SEED;
      code_q <= 4'sh0;
    end else begin
      acc1_q <= acc1_d; acc2_q <= acc2_d; acc3_q <= acc3_d;
      c2p_q <= c2p_d; c3p_q <= c3p_d; c3pp_q <= c3pp_d;
      lfsr_q <= lfsr_d;
      code_q <= code_d;
    end
  end

  property p_code_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      (!step && !reseed) |=> $stable(code_q);
  endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("modulator output moved without a reference step");

  property p_seed_load;
    @(posedge clk_sys) disable iff (sys_rst)
      (reseed && !sys_rst) |=> (acc1_q == $past(cfg.phase)) &&
      (code_q == 4'sh0);
  endproperty
  a_seed_load: assert property (p_seed_load)
    else $error("first accumulator not seeded from phase word");
endmodule

/* File: design/frac_sdm_fastlock_csr_ctrl.sv */
// synthesizer control: slip reducer, fast-lock timer, fractional interpolator
//
// Implementation choices: the Avalon-MM register port and the register offsets.
module frac_sdm_fastlock_csr_ctrl (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic [4:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  fsc_pkg::link_in_t       link_in,
  output logic [6:0]              extra_cells_q,
  output logic                    extra_cell_sink_q,
  output logic                    cp_gain_x16_q,
  output logic                    damping_switch_pin_o_q,
  output logic                    damping_switch_pin_oe_q,
  output logic signed [3:0]       sdm_code
);
  typedef enum logic [2:0] {
    CSR_IDLE   = 3'b001,
    CSR_RAMP   = 3'b010,
    CSR_UNWIND = 3'b100
  } csr_state_t;

  // input synchroniser: three stages, a change counts when two and three agree
  logic [3:0] s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
  logic       pfd_tick, slip_rise_up, slip_rise_dn, over_rise;

  always_comb begin
    filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q   <= 4'h0;
      s2_q   <= 4'h0;
      s3_q   <= 4'h0;
      filt_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      s1_q   <= link_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end

  assign pfd_tick     = filt_q[fsc_pkg::LNK_PFD] & ~prev_q[fsc_pkg::LNK_PFD];
  assign slip_rise_up = filt_q[fsc_pkg::LNK_UP] & ~prev_q[fsc_pkg::LNK_UP];
  assign slip_rise_dn = filt_q[fsc_pkg::LNK_DN] & ~prev_q[fsc_pkg::LNK_DN];
  assign over_rise    = filt_q[fsc_pkg::LNK_OVER] &
                        ~prev_q[fsc_pkg::LNK_OVER];

  // register file over the bus
  logic [31:0] cfg3_q, cfg3_d;
  logic [11:0] frac_q, frac_d, mod_q, mod_d, phase_q, phase_d;
  logic        dither_q, dither_d, reseed_q, reseed_d;
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic        req, acc_wr, cfg3_wr;
  logic        csr_en;
  logic [1:0]  mode;
  logic [11:0] tmr_val;

  // fast-lock and slip state, declared here for the status register
  logic        fl_q, fl_d;
  logic [11:0] tmr_q, tmr_d, mcnt_q, mcnt_d;
  logic        gain_d, sw_oe_d;
  csr_state_t  cs_q, cs_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [6:0]  cells_d;
  logic        sink_d;

  function automatic logic [11:0] clamp_mod(input logic [11:0] m);
    clamp_mod = (m < fsc_pkg::MOD_MIN) ? fsc_pkg::MOD_MIN : m;
  endfunction

  assign req     = avs_read | avs_write;
  assign acc_wr  = avs_write & ~wait_q;
  assign cfg3_wr = acc_wr & (avs_address == fsc_pkg::OFS_CFG3);
  assign csr_en  = cfg3_q[fsc_pkg::CSR_EN_BIT];
  assign mode    = cfg3_q[fsc_pkg::MODE_HI:fsc_pkg::MODE_LO];
  assign tmr_val = avs_writedata[fsc_pkg::TMR_HI:fsc_pkg::TMR_LO];

  always_comb begin
    cfg3_d   = cfg3_q;
    frac_d   = frac_q;
    mod_d    = mod_q;
    phase_d  = phase_q;
    dither_d = dither_q;
    reseed_d = 1'b0;
    rdata_d  = rdata_q;
    // one wait cycle, then the access completes
    wait_d   = ~(req & wait_q);
    if (acc_wr) begin
      unique case (avs_address)
        fsc_pkg::OFS_CFG3:    cfg3_d  = avs_writedata;
        fsc_pkg::OFS_FRAC:    frac_d  = avs_writedata[11:0];
        fsc_pkg::OFS_MODULUS:
          mod_d = clamp_mod(avs_writedata[11:0]);
        fsc_pkg::OFS_PHASE: begin
          phase_d  = avs_writedata[11:0];
          reseed_d = 1'b1;
        end
        fsc_pkg::OFS_CTRL: begin
          dither_d = avs_writedata[fsc_pkg::CTRL_DITHER_BIT];
          reseed_d = avs_writedata[fsc_pkg::CTRL_RESEED_BIT];
        end
        default: ;
      endcase
    end
    if (avs_read & wait_q) begin
      unique case (avs_address)
        fsc_pkg::OFS_CFG3:    rdata_d = cfg3_q;
        fsc_pkg::OFS_FRAC:    rdata_d = {20'h00000, frac_q};
        fsc_pkg::OFS_MODULUS: rdata_d = {20'h00000, mod_q};
        fsc_pkg::OFS_PHASE:   rdata_d = {20'h00000, phase_q};
        fsc_pkg::OFS_CTRL:    rdata_d = {31'h00000000, dither_q};
        fsc_pkg::OFS_STATUS:
          rdata_d = {16'h0000, 4'(sdm_code), 3'h0, cs_q, 1'b0,
                     extra_cell_sink_q, cnt_q, fl_q};
        default:              rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg3_q   <= fsc_pkg::RST_CFG3;
      frac_q   <= fsc_pkg::RST_FRAC;
      mod_q    <= fsc_pkg::RST_MODULUS;
      phase_q  <= fsc_pkg::RST_PHASE;
      dither_q <= 1'b0;
      reseed_q <= 1'b1;
      wait_q   <= 1'b1;
      rdata_q  <= 32'h0000_0000;
    end else begin
      cfg3_q   <= cfg3_d;
      frac_q   <= frac_d;
      mod_q    <= mod_d;
      phase_q  <= phase_d;
      dither_q <= dither_d;
      reseed_q <= reseed_d;
      wait_q   <= wait_d;
      rdata_q  <= rdata_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;

  // fast-lock timer: counts timer value times modulus reference periods
  always_comb begin
    fl_d   = fl_q;
    tmr_d  = tmr_q;
    mcnt_d = mcnt_q;
    if (cfg3_wr) begin
      // only mode 01 starts fast lock; 00 and 10 leave it off
      if ((avs_writedata[fsc_pkg::MODE_HI:fsc_pkg::MODE_LO]
           == fsc_pkg::MODE_FAST) && (tmr_val != 12'h000)) begin
        fl_d   = 1'b1;
        tmr_d  = tmr_val;
        mcnt_d = 12'h000;
      end else begin
        fl_d = 1'b0;
      end
    end else if (fl_q && pfd_tick) begin
      if (mcnt_q == mod_q - 12'h001) begin
        mcnt_d = 12'h000;
        tmr_d  = tmr_q - 12'h001;
        if (tmr_q == 12'h001) begin
          fl_d = 1'b0;
        end
      end else begin
        mcnt_d = mcnt_q + 12'h001;
      end
    end
    gain_d  = fl_d;
    sw_oe_d = fl_d;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fl_q                    <= 1'b0;
      tmr_q                   <= 12'h000;
      mcnt_q                  <= 12'h000;
      cp_gain_x16_q           <= 1'b0;
      damping_switch_pin_oe_q <= 1'b0;
      damping_switch_pin_o_q  <= 1'b0;
    end else begin
      fl_q                    <= fl_d;
      tmr_q                   <= tmr_d;
      mcnt_q                  <= mcnt_d;
      cp_gain_x16_q           <= gain_d;
      damping_switch_pin_oe_q <= sw_oe_d;
      damping_switch_pin_o_q  <= 1'b0;
    end
  end

  // cycle-slip reducer: thermometer of extra constant-current cells
  always_comb begin
    cs_d   = cs_q;
    cnt_d  = cnt_q;
    sink_d = extra_cell_sink_q;
    if (!csr_en) begin
      cs_d  = CSR_IDLE;
      cnt_d = 3'h0;
    end else begin
      unique case (cs_q)
        CSR_IDLE: begin
          if (slip_rise_up | slip_rise_dn) begin
            cs_d   = CSR_RAMP;
            cnt_d  = 3'h1;
            sink_d = slip_rise_dn & ~slip_rise_up;
          end
        end
        CSR_RAMP: begin
          if (over_rise) begin
            cs_d = CSR_UNWIND;
          end else if ((slip_rise_up | slip_rise_dn) &&
                       (cnt_q < fsc_pkg::MAX_CELLS)) begin
            cnt_d = cnt_q + 3'h1;
          end
        end
        CSR_UNWIND: begin
          if (cnt_q == 3'h0) begin
            cs_d = CSR_IDLE;
          end else if (pfd_tick) begin
            cnt_d = cnt_q - 3'h1;
          end
        end
      endcase
    end
    cells_d = 7'((8'h01 << cnt_d) - 8'h01);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cs_q              <= CSR_IDLE;
      cnt_q             <= 3'h0;
      extra_cells_q     <= 7'h00;
      extra_cell_sink_q <= 1'b0;
    end else begin
      cs_q              <= cs_d;
      cnt_q             <= cnt_d;
      extra_cells_q     <= cells_d;
      extra_cell_sink_q <= sink_d;
    end
  end

  fsc_pkg::sdm_cfg_t sdm_cfg;
  assign sdm_cfg = '{frac: frac_q, modulus: mod_q, phase: phase_q,
                     dither_en: dither_q};

  sigma_delta_interpolator u_sdm (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .cfg     (sdm_cfg),
    .reseed  (reseed_q),
    .step    (pfd_tick),
    .code_q  (sdm_code)
  );

  sequence s_fl_write;
    cfg3_wr && (tmr_val != 12'h000) &&
    (avs_writedata[fsc_pkg::MODE_HI:fsc_pkg::MODE_LO] == fsc_pkg::MODE_FAST);
  endsequence
  sequence s_wide_on;
    fl_q && (tmr_q == $past(tmr_val)) ##1 cp_gain_x16_q;
  endsequence

  property p_fl_start;
    @(posedge clk_sys) disable iff (sys_rst) s_fl_write |=> s_wide_on;
  endproperty
  a_fl_start: assert property (p_fl_start)
    else $error("fast lock did not start with loaded timer");

  property p_gain_switch;
    @(posedge clk_sys) disable iff (sys_rst)
      cp_gain_x16_q == damping_switch_pin_oe_q;
  endproperty
  a_gain_switch: assert property (p_gain_switch)
    else $error("switch pin and pump gain disagree");

  property p_fl_gain;
    @(posedge clk_sys) disable iff (sys_rst) fl_q |-> cp_gain_x16_q;
  endproperty
  a_fl_gain: assert property (p_fl_gain)
    else $error("pump gain not raised during wide bandwidth");

  property p_fl_end;
    @(posedge clk_sys) disable iff (sys_rst)
      (fl_q && pfd_tick && !cfg3_wr && tmr_q == 12'h001 &&
       mcnt_q == mod_q - 12'h001) |=> ##1 (!cp_gain_x16_q &&
       !damping_switch_pin_oe_q);
  endproperty
  a_fl_end: assert property (p_fl_end)
    else $error("fast lock did not end at timer expiry");

  property p_csr_off;
    @(posedge clk_sys) disable iff (sys_rst)
      !csr_en |=> (extra_cells_q == 7'h00);
  endproperty
  a_csr_off: assert property (p_csr_off)
    else $error("extra cells on while slip reducer disabled");

  property p_cell_add;
    @(posedge clk_sys) disable iff (sys_rst)
      (csr_en && cs_q == CSR_RAMP && !over_rise &&
       (slip_rise_up | slip_rise_dn) && cnt_q < 3'h7) |=>
      (cnt_q == $past(cnt_q) + 3'h1);
  endproperty
  a_cell_add: assert property (p_cell_add)
    else $error("near-slip did not add exactly one cell");

  property p_unwind;
    @(posedge clk_sys) disable iff (sys_rst)
      (csr_en && cs_q == CSR_UNWIND && pfd_tick && cnt_q != 3'h0) |=>
      (cnt_q == $past(cnt_q) - 3'h1);
  endproperty
  a_unwind: assert property (p_unwind)
    else $error("cells not removed one at a time");

  property p_bus_ack;
    @(posedge clk_sys) disable iff (sys_rst)
      (req && wait_q) |=> !avs_waitrequest ##1 (avs_waitrequest || !req);
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("bus request not answered after one wait cycle");
endmodule

/* File: verif/loop_vco_model.sv */
// stand-in for loop filter and oscillator: reference and slip event pins
module loop_vco_model #(
  parameter int PFD_HALF = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         up_req,
  input  wire logic         dn_req,
  input  wire logic         over_req,
  output fsc_pkg::link_in_t link_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0;
  int up_n = 0;
  int dn_n = 0;
  int ov_n = 0;
  // reference runs free at even duty; event pins held 4 clk to pass filter
  always @(posedge clk_sys) begin
    ph <= (ph + 1) % (2 * PFD_HALF);
    up_n <= up_req ? 4 : (up_n > 0 ? up_n - 1 : 0);
    dn_n <= dn_req ? 4 : (dn_n > 0 ? dn_n - 1 : 0);
    ov_n <= over_req ? 4 : (ov_n > 0 ? ov_n - 1 : 0);
    link_in.pfd_ref <= (ph < PFD_HALF);
    link_in.slip_up <= (up_n != 0);
    link_in.slip_dn <= (dn_n != 0);
    link_in.overshoot <= (ov_n != 0);
  end
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the synthesizer control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int L54 = 324;
  logic              clk_sys;
  logic              sys_rst;
  logic [4:0]        avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  fsc_pkg::link_in_t link_in;
  logic [6:0]        extra_cells_q;
  logic              sink;
  logic              gain;
  logic              sw_o;
  logic              sw_oe;
  logic signed [3:0] sdm_code;
  logic              up_req;
  logic              dn_req;
  logic              over_req;
  logic [31:0]       rd;
  logic signed [3:0] codes [$];
  logic signed [3:0] first [$];
  logic [31:0]       exp_reg [int];
  int                miscompares;
  int                compares;
  int                seed;
  int                frac;
  int                t;
  int                n;
  int                sum;

  frac_sdm_fastlock_csr_ctrl DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_in(link_in),
    .extra_cells_q(extra_cells_q), .extra_cell_sink_q(sink),
    .cp_gain_x16_q(gain), .damping_switch_pin_o_q(sw_o),
    .damping_switch_pin_oe_q(sw_oe), .sdm_code(sdm_code));
  loop_vco_model far (.clk_sys(clk_sys), .up_req(up_req), .dn_req(dn_req),
    .over_req(over_req), .link_in(link_in));

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tmo(input string nm);
    miscompares++;
    $display("[FAIL] %s expected done seen timeout", nm);
    wrap_up;
  endtask

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
    if (k >= 20) tmo("waitrequest");
  endtask

  // register model: modulus floors at 2, reseed bit reads back 0
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a == fsc_pkg::OFS_CFG3) exp_reg[int'(a)] = d;
    else if (a == fsc_pkg::OFS_CTRL) exp_reg[int'(a)] = d & 32'h1;
    else if (a == fsc_pkg::OFS_MODULUS && d < 2) exp_reg[int'(a)] = 32'h2;
    else exp_reg[int'(a)] = d & 32'hFFF;
  endtask

  task automatic rreg(input string nm, input logic [4:0] a);
    bus(1'b0, a, 32'h0);
    chk(nm, exp_reg.exists(int'(a)) ? exp_reg[int'(a)] : 32'h0, rd);
  endtask

  task automatic pfd_rise;
    int k;
    k = 0;
    while (link_in.pfd_ref !== 1'b0 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    while (link_in.pfd_ref !== 1'b1 && k < 40) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 40) tmo("reference edge");
  endtask

  task automatic slip(input int kind, input int w);
    up_req <= (kind == 0);
    dn_req <= (kind == 1);
    over_req <= (kind == 2);
    @(posedge clk_sys);
    up_req <= 1'b0;
    dn_req <= 1'b0;
    over_req <= 1'b0;
    repeat (w) @(posedge clk_sys);
  endtask

  // at most one cell dropped per reference period until none remain
  task automatic unwind;
    int p;
    int c;
    p = $countones(extra_cells_q);
    slip(2, 0);
    for (int k = 0; k < 16 && p != 0; k++) begin
      pfd_rise;
      c = $countones(extra_cells_q);
      chk("unwind step", 1, c <= p && c >= p - 1);
      p = c;
    end
    chk("cells after unwind", 0, extra_cells_q);
  endtask

  task automatic collect(input int cnt);
    codes.delete();
    repeat (cnt) begin
      pfd_rise;
      codes.push_back(sdm_code);
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    up_req = 1'b0;
    dn_req = 1'b0;
    over_req = 1'b0;
    seed = 54;
    miscompares = 0;
    compares = 0;
    exp_reg[int'(fsc_pkg::OFS_CFG3)] = fsc_pkg::RST_CFG3;
    exp_reg[int'(fsc_pkg::OFS_FRAC)] = 32'(fsc_pkg::RST_FRAC);
    exp_reg[int'(fsc_pkg::OFS_MODULUS)] = 32'(fsc_pkg::RST_MODULUS);
    exp_reg[int'(fsc_pkg::OFS_PHASE)] = 32'(fsc_pkg::RST_PHASE);
    exp_reg[int'(fsc_pkg::OFS_CTRL)] = 32'h0;
    repeat (20) @(posedge clk_sys);
    chk("waitrequest in reset", 1, avs_waitrequest);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a < 28; a += 4) if (a != 20) rreg("reset value", 5'(a));
    bus(1'b0, fsc_pkg::OFS_STATUS, 32'h0);
    chk("status reset", 32'h040, rd & 32'hFFF);
    wreg(fsc_pkg::OFS_MODULUS, 32'h1);
    rreg("modulus floor", fsc_pkg::OFS_MODULUS);
    wreg(fsc_pkg::OFS_MODULUS, 32'hFFF);
    rreg("modulus top", fsc_pkg::OFS_MODULUS);
    $display("test registers done");

    wreg(fsc_pkg::OFS_CFG3, 32'h0);
    slip(0, 12);
    chk("cells disabled", 0, extra_cells_q);
    wreg(fsc_pkg::OFS_CFG3, 32'h1 << 18);
    slip(0, 12);
    chk("first cell", 32'h1, extra_cells_q);
    chk("source polarity", 0, sink);
    unwind;
    for (int i = 1; i <= 8; i++) begin
      slip(1, 12);
      n = (i > 7) ? 7 : i;
      chk("cells ramp", (32'h1 << n) - 1, extra_cells_q);
    end
    chk("sink polarity", 1, sink);
    bus(1'b0, fsc_pkg::OFS_STATUS, 32'h0);
    chk("status cells", 32'h1E, rd & 32'h1E);
    unwind;
    $display("test slip reducer done");

    wreg(fsc_pkg::OFS_MODULUS, 32'h3);
    for (int m = 2; m >= 0; m -= 2) begin
      wreg(fsc_pkg::OFS_CFG3, (32'(m) << 15) | (32'h2 << 3));
      repeat (20) @(posedge clk_sys);
      chk("no fast lock", 0, {gain, sw_oe});
    end
    t = 1 + ($unsigned($random(seed)) % 3);
    wreg(fsc_pkg::OFS_CFG3, 32'h8000 | (32'(t) << 3));
    n = 0;
    while (gain !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      n++;
    end
    chk("wide bandwidth start", 1, n < 10);
    n = 0;
    while (gain === 1'b1 && n < 400) begin
      chk("switch enable", 1, sw_oe);
      chk("switch level", 0, sw_o);
      @(posedge clk_sys);
      n++;
    end
    chk("wide time", 1, n >= (3 * t - 1) * 8 && n <= (3 * t + 1) * 8);
    chk("switch release", 0, sw_oe);
    $display("test fast lock done");

    frac = 1 + ($unsigned($random(seed)) % 53);
    wreg(fsc_pkg::OFS_MODULUS, 32'd54);
    wreg(fsc_pkg::OFS_FRAC, 32'(frac));
    rreg("fraction", fsc_pkg::OFS_FRAC);
    wreg(fsc_pkg::OFS_CTRL, 32'h0);
    pfd_rise;
    wreg(fsc_pkg::OFS_PHASE, 32'h1);
    collect(2 * L54 + 4);
    sum = 0;
    n = 0;
    // first codes carry the zeroed carry history of the reseed
    for (int i = 4; i < L54 + 4; i++) begin
      sum += codes[i];
      if (codes[i] !== codes[i + L54]) n++;
    end
    chk("repeat length", 0, n);
    chk("mean step", 6 * frac, sum);
    first = codes;
    pfd_rise;
    wreg(fsc_pkg::OFS_PHASE, 32'h1);
    collect(64);
    n = 0;
    for (int i = 0; i < 64; i++) if (codes[i] !== first[i]) n++;
    chk("seeded sequence", 0, n);
    wreg(fsc_pkg::OFS_CTRL, 32'h1);
    rreg("control", fsc_pkg::OFS_CTRL);
    collect(2 * L54);
    n = 0;
    for (int i = 0; i < L54; i++) if (codes[i] !== codes[i + L54]) n++;
    chk("dither breaks repeat", 1, n > 0);
    $display("test modulator done");
    wrap_up;
  end
endmodule
